// [pkg/chg_ctrl_pkg.sv]
// Constants, register map and types for the charger host/default-mode and cycle control.
package chg_ctrl_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SECOND_NS       = 1000000000;
  localparam int SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int INT_PULSE_NS    = 256000;
  localparam int INT_PULSE_CYCLES = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESC_W         = 26;
  localparam int INT_CNT_W       = 14;

  // Register byte addresses
  localparam logic [7:0] ADDR_CHARGE_CURRENT_SETTING   = 8'h00;
  localparam logic [7:0] ADDR_CHARGE_VOLTAGE_TARGET   = 8'h01;
  localparam logic [7:0] ADDR_TERMINATION_CURRENT_SETTING  = 8'h02;
  localparam logic [7:0] ADDR_LOWV   = 8'h03;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_FLAGS  = 8'h07;

  // Reset values: charge_current_setting 50 mA/lsb, charge_voltage_target 3.5 V + 5 mV/lsb, termination_current_setting 50 mA/lsb, lowv 2.6 V + 100 mV/lsb
  localparam logic [7:0] CHARGE_CURRENT_SETTING_RST  = 8'h46;  // 3.500 A
  localparam logic [7:0] CHARGE_CURRENT_SETTING_MAX  = 8'h78;  // 6.000 A
  localparam logic [7:0] CHARGE_VOLTAGE_TARGET_RST  = 8'haa;  // 4.350 V
  localparam logic [7:0] TERMINATION_CURRENT_SETTING_RST = 8'h14;  // 1.000 A
  localparam logic [7:0] LOWV_RST  = 8'h09;  // 3.5 V
  localparam logic [7:0] CTRL_RST  = 8'he6;  // Watchdog 160 s, timer 12 h, timer and 2x on

  // Control register fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_TMREN_BIT = 1;
  localparam int CTRL_TMR2X_BIT = 2;
  localparam int CTRL_TSEL_LSB  = 4;
  localparam int CTRL_WSEL_LSB  = 6;
  // Command register fields (self clearing)
  localparam int CMD_WDRST_BIT  = 0;
  localparam int CMD_REGRST_BIT = 1;
  // Flag register fields
  localparam int FLAG_TERM  = 0;
  localparam int FLAG_WD    = 1;
  localparam int FLAG_PHASE = 2;
  localparam int FLAG_TMR   = 3;

  // Watchdog periods in seconds; code 0 disables the watchdog
  localparam logic [7:0] WD_CODE1_S = 8'h28;  // 40 s
  localparam logic [7:0] WD_CODE2_S = 8'h50;  // 80 s
  localparam logic [7:0] WD_CODE3_S = 8'ha0;  // 160 s

  // Safety timer limits in seconds (5 h, 8 h, 12 h, 20 h)
  localparam logic [16:0] TMR_CODE0_S = 17'h04650;
  localparam logic [16:0] TMR_CODE1_S = 17'h07080;
  localparam logic [16:0] TMR_CODE2_S = 17'h0a8c0;
  localparam logic [16:0] TMR_CODE3_S = 17'h11940;

  // Synchronised analog status pins
  localparam int PIN_CONV  = 0;
  localparam int PIN_LOWV  = 1;
  localparam int PIN_CHARGE_VOLTAGE_TARGET  = 2;
  localparam int PIN_TERMINATION_CURRENT_SETTING = 3;
  localparam int PIN_DPM   = 4;
  localparam int PIN_THERM = 5;
  localparam int PIN_N     = 6;

  // Charge phase codes
  localparam logic [2:0] PHASE_OFF = 3'h0;
  localparam logic [2:0] PHASE_CC  = 3'h3;
  localparam logic [2:0] PHASE_CV  = 3'h4;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_CC  = 3'b010,
    ST_CV  = 3'b100
  } chg_state_t;

endpackage : chg_ctrl_pkg

// [rtl/chg_ctrl.sv]
// Charger control: watchdog host/default mode, charge cycle sequencer, status and pulse.
//
// Overview of operation
// - Watchdog timeout stops charging, enters default mode
// - Default mode: charge needs enable plus restart
// - Watchdog status high in default mode
// - Power-on: default mode, defaults, idle, no charge
// - Restart bit write enters host mode
// - Period code zero disables the watchdog
// - Expiry restores defaults except exempt fields
// - Expired watchdog blocks charge regardless of enable
// - Register reset restores all but status and flags
// - Enabled above threshold runs cycle autonomously
// - Defaults 3.5V, 4.350V, 3.5A, 1A, 12h
// - Start needs converter, enable, current, voltage, no fault
// - Terminate on low current outside regulation
// - Termination pulses interrupt, clears enable bit
// - Phase codes 000/011/100; change pulses interrupt
// - Regulation suspends termination, halves timer rate
// - No automatic recharge; enable must toggle
// - Charge current setting reaches six amperes
// - Each event gives 256 us low pulse
// - Flags clear on read, need new edge
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module chg_ctrl
  import chg_ctrl_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES,
  parameter int INT_CYCLES = INT_PULSE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       conv_started_in,
  input  wire logic       vbat_above_lowv_in,
  input  wire logic       vbat_at_charge_voltage_target_in,
  input  wire logic       ibat_below_termination_current_setting_in,
  input  wire logic       dpm_active_in,
  input  wire logic       therm_reg_active_in,
  output logic            charge_run_out,
  output logic            high_impedance_idle_out,
  output logic      [7:0] charge_current_setting_out,
  output logic      [7:0] charge_voltage_target_out,
  output logic      [7:0] termination_current_setting_out,
  output logic      [7:0] lowv_out,
  output logic      [2:0] charge_phase_status_out,
  output logic            watchdog_expired_status_out,
  output logic            int_n_out
);

  typedef struct packed {
    logic [PIN_N-1:0]     sync1;
    logic [PIN_N-1:0]     sync2;
    logic [PRESC_W-1:0]   presc;
    logic [7:0]           wd_sec;
    logic                 expired;
    logic                 half_ph;
    logic [16:0]          tmr_sec;
    logic                 tmr_fault;
    logic [7:0]           charge_current_setting;
    logic [7:0]           charge_voltage_target;
    logic [7:0]           termination_current_setting;
    logic [7:0]           lowv;
    logic [7:0]           ctrl;
    chg_state_t           state;
    logic [2:0]           phase;
    logic [3:0]           flags;
    logic [INT_CNT_W-1:0] int_cnt;
    logic                 int_n;
    logic [7:0]           rdata;
    logic                 term_ev;
    logic                 run;
    logic                 idle;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       sec_tick;
  logic [7:0] wd_limit;
  logic [16:0] tmr_limit;
  logic       regulating;
  logic       can_start;
  logic       wd_kick;
  logic       reg_rst;
  logic       wd_fire;
  logic       event_any;

  // Sync pins only cross through the second stage; nothing else reads stage one
  always_comb begin
    sec_tick   = (st_r.presc == PRESC_W'(SEC_CYCLES - 1));
    regulating = st_r.sync2[PIN_DPM] | st_r.sync2[PIN_THERM];
    wd_kick    = wr_in && (addr_in == ADDR_CMD) && wdata_in[CMD_WDRST_BIT];
    reg_rst    = wr_in && (addr_in == ADDR_CMD) && wdata_in[CMD_REGRST_BIT];
    unique case (st_r.ctrl[CTRL_WSEL_LSB +: 2])
      2'd1:    wd_limit = WD_CODE1_S;
      2'd2:    wd_limit = WD_CODE2_S;
      2'd3:    wd_limit = WD_CODE3_S;
      default: wd_limit = 8'h00;
    endcase
    unique case (st_r.ctrl[CTRL_TSEL_LSB +: 2])
      2'd0:    tmr_limit = TMR_CODE0_S;
      2'd1:    tmr_limit = TMR_CODE1_S;
      2'd2:    tmr_limit = TMR_CODE2_S;
      default: tmr_limit = TMR_CODE3_S;
    endcase
    // Watchdog period zero never fires
    wd_fire  = !st_r.expired && (wd_limit != 8'h00) && sec_tick
               && (st_r.wd_sec + 8'h01 >= wd_limit);
    can_start = !st_r.expired && st_r.ctrl[CTRL_EN_BIT] && (st_r.charge_current_setting != 8'h00)
                && st_r.sync2[PIN_CONV] && st_r.sync2[PIN_LOWV]
                && !st_r.tmr_fault;
  end

  // Next-state logic; everything holds while ce_in is low
  always_comb begin
    st_nxt    = st_r;
    event_any = 1'b0;
    if (ce_in) begin
      // Read data and the termination marker last one enabled cycle
      st_nxt.rdata   = 8'h00;
      st_nxt.term_ev = 1'b0;
      // Clear on read first, so an event in the same cycle sets its flag again
      if (rd_in && (addr_in == ADDR_FLAGS)) begin
        st_nxt.flags = 4'h0;
      end
      st_nxt.sync1 = {therm_reg_active_in, dpm_active_in, ibat_below_termination_current_setting_in,
                      vbat_at_charge_voltage_target_in, vbat_above_lowv_in, conv_started_in};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.presc = sec_tick ? '0 : st_r.presc + PRESC_W'(1);

      // Register writes; current setting clamps at the 6 A ceiling
      if (wr_in) begin
        unique case (addr_in)
          ADDR_CHARGE_CURRENT_SETTING:  st_nxt.charge_current_setting  = (wdata_in > CHARGE_CURRENT_SETTING_MAX) ? CHARGE_CURRENT_SETTING_MAX : wdata_in;
          ADDR_CHARGE_VOLTAGE_TARGET:  st_nxt.charge_voltage_target  = wdata_in;
          ADDR_TERMINATION_CURRENT_SETTING: st_nxt.termination_current_setting = wdata_in;
          ADDR_LOWV:  st_nxt.lowv  = wdata_in;
          ADDR_CTRL:  st_nxt.ctrl  = wdata_in;
          default:    ;
        endcase
      end

      // Register reset keeps status and flags, defaults everything else
      if (reg_rst) begin
        st_nxt.charge_current_setting  = CHARGE_CURRENT_SETTING_RST;
        st_nxt.charge_voltage_target  = CHARGE_VOLTAGE_TARGET_RST;
        st_nxt.termination_current_setting = TERMINATION_CURRENT_SETTING_RST;
        st_nxt.lowv  = LOWV_RST;
        st_nxt.ctrl  = CTRL_RST;
      end

      // Watchdog second counter; a kick wins over a same-cycle expiry
      if (wd_kick) begin
        st_nxt.expired = 1'b0;
        st_nxt.wd_sec  = 8'h00;
      end else if (wd_fire) begin
        st_nxt.expired = 1'b1;
        st_nxt.wd_sec  = 8'h00;
        // Watchdog period field is exempt so the selected period stays in force
        st_nxt.charge_current_setting  = CHARGE_CURRENT_SETTING_RST;
        st_nxt.charge_voltage_target  = CHARGE_VOLTAGE_TARGET_RST;
        st_nxt.termination_current_setting = TERMINATION_CURRENT_SETTING_RST;
        st_nxt.lowv  = LOWV_RST;
        st_nxt.ctrl  = {st_r.ctrl[CTRL_WSEL_LSB +: 2], CTRL_RST[5:0]};
        st_nxt.flags[FLAG_WD] = 1'b1;
        event_any = 1'b1;
      end else if (!st_r.expired && sec_tick) begin
        st_nxt.wd_sec = (wd_limit == 8'h00) ? 8'h00 : st_r.wd_sec + 8'h01;
      end

      // Charge cycle sequencer
      unique case (st_r.state)
        ST_OFF: begin
          if (can_start) begin
            st_nxt.state = ST_CC;
          end
        end
        ST_CC: begin
          if (!can_start) begin
            st_nxt.state = ST_OFF;
          end else if (st_r.sync2[PIN_CHARGE_VOLTAGE_TARGET]) begin
            st_nxt.state = ST_CV;
          end
        end
        ST_CV: begin
          if (!can_start) begin
            st_nxt.state = ST_OFF;
          end else if (st_r.sync2[PIN_TERMINATION_CURRENT_SETTING] && !regulating) begin
            st_nxt.state = ST_OFF;
            st_nxt.ctrl[CTRL_EN_BIT] = 1'b0;
            st_nxt.flags[FLAG_TERM]  = 1'b1;
            st_nxt.term_ev           = 1'b1;
            event_any = 1'b1;
          end
        end
      endcase
      // Expiry defaults the enable bit too, so the cycle stops at once
      if (wd_fire) begin
        st_nxt.state = ST_OFF;
      end

      // Safety timer; under regulation it advances every other second
      if (st_r.state == ST_OFF) begin
        st_nxt.tmr_sec = 17'h00000;
        st_nxt.half_ph = 1'b0;
      end else if (sec_tick && st_r.ctrl[CTRL_TMREN_BIT] && !st_r.tmr_fault) begin
        if (regulating && st_r.ctrl[CTRL_TMR2X_BIT] && !st_r.half_ph) begin
          st_nxt.half_ph = 1'b1;
        end else begin
          st_nxt.half_ph = 1'b0;
          st_nxt.tmr_sec = st_r.tmr_sec + 17'h00001;
          if (st_r.tmr_sec + 17'h00001 >= tmr_limit) begin
            st_nxt.tmr_fault = 1'b1;
            st_nxt.flags[FLAG_TMR] = 1'b1;
            event_any = 1'b1;
          end
        end
      end
      // Fault lasts until the enable bit drops, by software write or on watchdog expiry
      if (!st_nxt.ctrl[CTRL_EN_BIT]) begin
        st_nxt.tmr_fault = 1'b0;
      end

      // Phase code follows the sequencer state
      unique case (st_nxt.state)
        ST_CC:   st_nxt.phase = PHASE_CC;
        ST_CV:   st_nxt.phase = PHASE_CV;
        default: st_nxt.phase = PHASE_OFF;
      endcase
      // Run and idle levels registered so the outputs come from flops
      st_nxt.run  = (st_nxt.state != ST_OFF);
      st_nxt.idle = (st_nxt.state == ST_OFF);
      if (st_nxt.phase != st_r.phase) begin
        st_nxt.flags[FLAG_PHASE] = 1'b1;
        event_any = 1'b1;
      end

      // Register reads; data stands only in the following cycle
      if (rd_in) begin
        unique case (addr_in)
          ADDR_CHARGE_CURRENT_SETTING:   st_nxt.rdata = st_r.charge_current_setting;
          ADDR_CHARGE_VOLTAGE_TARGET:   st_nxt.rdata = st_r.charge_voltage_target;
          ADDR_TERMINATION_CURRENT_SETTING:  st_nxt.rdata = st_r.termination_current_setting;
          ADDR_LOWV:   st_nxt.rdata = st_r.lowv;
          ADDR_CTRL:   st_nxt.rdata = st_r.ctrl;
          ADDR_CMD:    st_nxt.rdata = 8'h00;
          ADDR_STATUS: st_nxt.rdata = {3'h0, st_r.tmr_fault, st_r.phase, st_r.expired};
          ADDR_FLAGS:  st_nxt.rdata = {4'h0, st_r.flags};
          default:     st_nxt.rdata = 8'h00;
        endcase
      end

      // Interrupt pulse; a new event restarts the full low time
      if (event_any) begin
        st_nxt.int_n   = 1'b0;
        st_nxt.int_cnt = INT_CNT_W'(INT_CYCLES - 1);
      end else if (!st_r.int_n) begin
        if (st_r.int_cnt == '0) begin
          st_nxt.int_n = 1'b1;
        end else begin
          st_nxt.int_cnt = st_r.int_cnt - INT_CNT_W'(1);
        end
      end
    end
  end

  // State register; power-on lands in default mode with dog expired
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r         <= '0;
      st_r.expired <= 1'b1;
      st_r.charge_current_setting    <= CHARGE_CURRENT_SETTING_RST;
      st_r.charge_voltage_target    <= CHARGE_VOLTAGE_TARGET_RST;
      st_r.termination_current_setting   <= TERMINATION_CURRENT_SETTING_RST;
      st_r.lowv    <= LOWV_RST;
      st_r.ctrl    <= CTRL_RST;
      st_r.state   <= ST_OFF;
      st_r.phase   <= PHASE_OFF;
      st_r.int_n   <= 1'b1;
      st_r.idle    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All outputs straight from the state register
  assign rdata_out                   = st_r.rdata;
  assign charge_run_out              = st_r.run;
  assign high_impedance_idle_out     = st_r.idle;
  assign charge_current_setting_out                    = st_r.charge_current_setting;
  assign charge_voltage_target_out                    = st_r.charge_voltage_target;
  assign termination_current_setting_out                   = st_r.termination_current_setting;
  assign lowv_out                    = st_r.lowv;
  assign charge_phase_status_out     = st_r.phase;
  assign watchdog_expired_status_out = st_r.expired;
  assign int_n_out                   = st_r.int_n;

  // Helper: length of the current low pulse
  logic [15:0] low_len_r;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      low_len_r <= 16'h0000;
    end else if (ce_in) begin
      // A new event restarts the measured low time
      low_len_r <= st_nxt.int_n ? 16'h0000 : (event_any ? 16'h0001 : low_len_r + 16'h0001);
    end
  end

  property p_wd_expire;
    @(posedge clk_in) disable iff (srst_in)
    (ce_in && wd_fire && !wd_kick) |=> (watchdog_expired_status_out && !charge_run_out);
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry missed");

  property p_no_charge_expired;
    @(posedge clk_in) disable iff (srst_in)
    watchdog_expired_status_out |=> !charge_run_out;
  endproperty
  a_no_charge_expired: assert property (p_no_charge_expired) else $error("charging while expired");

  property p_kick_host;
    @(posedge clk_in) disable iff (srst_in)
    (ce_in && wd_kick) |=> !watchdog_expired_status_out;
  endproperty
  a_kick_host: assert property (p_kick_host) else $error("restart did not enter host mode");

  property p_wd_off;
    @(posedge clk_in) disable iff (srst_in)
    (!watchdog_expired_status_out && st_r.ctrl[CTRL_WSEL_LSB +: 2] == 2'd0)
      |=> !watchdog_expired_status_out;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired");

  property p_term;
    @(posedge clk_in) disable iff (srst_in)
    st_r.term_ev |-> (!st_r.ctrl[CTRL_EN_BIT] && !int_n_out && !charge_run_out);
  endproperty
  a_term: assert property (p_term) else $error("termination effects missing");

  property p_phase_int;
    @(posedge clk_in) disable iff (srst_in)
    (charge_phase_status_out != $past(charge_phase_status_out)) |-> !int_n_out;
  endproperty
  a_phase_int: assert property (p_phase_int) else $error("phase change without pulse");

  property p_pulse_max;
    @(posedge clk_in) disable iff (srst_in)
    low_len_r <= 16'(INT_CYCLES);
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("interrupt pulse too long");

  property p_pulse_len;
    @(posedge clk_in) disable iff (srst_in)
    $rose(int_n_out) |-> ($past(low_len_r) == 16'(INT_CYCLES));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse length wrong");

  property p_flag_clear;
    @(posedge clk_in) disable iff (srst_in)
    (ce_in && rd_in && addr_in == ADDR_FLAGS && !event_any) |=> (st_r.flags == 4'h0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared on read");

  property p_no_recharge;
    @(posedge clk_in) disable iff (srst_in)
    (!charge_run_out && !st_r.ctrl[CTRL_EN_BIT] && !wr_in) |=> !charge_run_out;
  endproperty
  a_no_recharge: assert property (p_no_recharge) else $error("automatic recharge");

  c_start: cover property (@(posedge clk_in) disable iff (srst_in) $rose(charge_run_out));
  c_term: cover property (@(posedge clk_in) disable iff (srst_in) st_r.term_ev);
  c_expire: cover property (@(posedge clk_in) disable iff (srst_in)
    $rose(watchdog_expired_status_out));
  c_taper: cover property (@(posedge clk_in) disable iff (srst_in)
    charge_phase_status_out == PHASE_CV);

endmodule : chg_ctrl

`default_nettype wire

// [tb/chg_batt_model.sv]
// Battery and regulation loop model standing on the far side of the charger control.
`timescale 1ns/1ps
`default_nettype none

module chg_batt_model (
  input  wire logic       link_clk_in,
  input  wire logic       drain_in,
  input  wire logic       charge_run_in,
  input  wire logic [1:0] reg_req_in,
  output logic            conv_out,
  output logic            lowv_ok_out,
  output logic            at_charge_voltage_target_out,
  output logic            ibat_low_out,
  output logic            dpm_out,
  output logic            therm_out
);
  logic [3:0] vbat_r;
  logic [3:0] taper_r;

  // Cell level steps on the slow link clock, so the pins change out of phase
  always_ff @(posedge link_clk_in) begin
    if (drain_in) begin
      vbat_r  <= 4'h0;
      taper_r <= 4'h0;
    end else begin
      if (!charge_run_in && vbat_r < 4'h4) vbat_r <= vbat_r + 4'h1;
      else if (charge_run_in && vbat_r < 4'ha) vbat_r <= vbat_r + 4'h1;
      // Current only tapers while held at the target voltage
      if (!charge_run_in || vbat_r < 4'ha) taper_r <= 4'h0;
      else if (taper_r < 4'h6) taper_r <= taper_r + 4'h1;
    end
  end

  // Status levels seen by the control block
  assign conv_out     = ~drain_in;
  assign lowv_ok_out  = (vbat_r >= 4'h4);
  assign at_charge_voltage_target_out  = (vbat_r >= 4'ha);
  assign ibat_low_out = (taper_r >= 4'h6);
  assign dpm_out      = reg_req_in[0];
  assign therm_out    = reg_req_in[1];
endmodule : chg_batt_model
`default_nettype wire

// [tb/test_chg_ctrl.sv]
// Self-checking bench for the charger control block.
`timescale 1ns/1ps
`default_nettype none

module test_chg_ctrl;
  import chg_ctrl_pkg::*;
  localparam int SEC_C = 10;  // Short second keeps watchdog runs brief
  localparam int INT_C = 8;
  logic       clk_in   = 1'b0;
  logic       link_clk = 1'b0;
  logic       srst_in  = 1'b1;
  logic [7:0] addr_in  = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in    = 1'b0;
  logic       rd_in    = 1'b0;
  logic       drain    = 1'b1;
  logic [1:0] reg_req  = 2'h0;
  logic [7:0] rdata_out, charge_current_setting_out, charge_voltage_target_out, termination_current_setting_out, lowv_out;
  logic [2:0] phase;
  logic       run, idle, expired, int_n;
  logic       conv, lowv_ok, at_charge_voltage_target, ibat_low, input_power_management, therm;
  int         failures    = 0;
  int         check_count = 0;
  int         seed        = 86;
  int         i, n, k;
  logic [7:0] v;

  // Core clock and an unrelated slow link clock
  always #10 clk_in = ~clk_in;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end

  chg_ctrl #(.SEC_CYCLES(SEC_C), .INT_CYCLES(INT_C)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .conv_started_in(conv), .vbat_above_lowv_in(lowv_ok),
    .vbat_at_charge_voltage_target_in(at_charge_voltage_target), .ibat_below_termination_current_setting_in(ibat_low),
    .dpm_active_in(input_power_management), .therm_reg_active_in(therm), .charge_run_out(run),
    .high_impedance_idle_out(idle), .charge_current_setting_out(charge_current_setting_out), .charge_voltage_target_out(charge_voltage_target_out),
    .termination_current_setting_out(termination_current_setting_out), .lowv_out(lowv_out),
    .charge_phase_status_out(phase), .watchdog_expired_status_out(expired),
    .int_n_out(int_n)
  );

  chg_batt_model batt_u (
    .link_clk_in(link_clk), .drain_in(drain), .charge_run_in(run),
    .reg_req_in(reg_req), .conv_out(conv), .lowv_ok_out(lowv_ok),
    .at_charge_voltage_target_out(at_charge_voltage_target), .ibat_low_out(ibat_low), .dpm_out(input_power_management),
    .therm_out(therm)
  );

  task automatic results;
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Sample a little after the edge so register updates have landed
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
    if (nm != "") chk(nm, exp, v);
  endtask : rchk

  task automatic wphase(input logic [2:0] exp, input int lim);
    for (n = 0; n < lim && phase !== exp; n++) tick(1);
    chk("phase", {5'h0, exp}, {5'h0, phase});
  endtask : wphase

  // Waits for a low pulse and measures its length in cycles
  task automatic pulse(input int lim);
    for (n = 0; n < lim && int_n !== 1'b0; n++) tick(1);
    for (i = 0; i < 200 && int_n === 1'b0; i++) tick(1);
    chk("int_len", 8'(INT_C), 8'(i));
  endtask : pulse

  initial begin
    #1000000;
    failures++;
    results;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    drain   <= 1'b0;
    tick(1);
    // Power-on state and defaults
    chk("expired", 8'h01, {7'h0, expired});
    chk("idle", 8'h01, {7'h0, idle});
    chk("int_n", 8'h01, {7'h0, int_n});
    chk("charge_current_setting", 8'h46, charge_current_setting_out);
    chk("charge_voltage_target", 8'haa, charge_voltage_target_out);
    chk("termination_current_setting", 8'h14, termination_current_setting_out);
    chk("lowv", 8'h09, lowv_out);
    rchk(ADDR_CTRL, 8'he6, "ctrl");
    rchk(ADDR_STATUS, 8'h01, "status");
    rchk(8'h20, 8'h00, "unmapped");
    // Enable alone does nothing while expired, even with a good cell
    wr(ADDR_CTRL, 8'he7);
    tick(100);
    chk("run", 8'h00, {7'h0, run});
    chk("phase", 8'h00, {5'h0, phase});
    // Restart enters host mode but zero current blocks the start
    wr(ADDR_CHARGE_CURRENT_SETTING, 8'h00);
    wr(ADDR_CMD, 8'h01);
    tick(2);
    chk("expired", 8'h00, {7'h0, expired});
    rchk(ADDR_CMD, 8'h00, "cmd");
    tick(40);
    chk("run", 8'h00, {7'h0, run});
    wr(ADDR_CHARGE_CURRENT_SETTING, 8'h46);
    pulse(50);
    chk("run", 8'h01, {7'h0, run});
    chk("phase", 8'h03, {5'h0, phase});
    reg_req <= 2'b01;
    wphase(3'h4, 200);
    // Termination held off by regulation loops
    tick(150);
    chk("phase", 8'h04, {5'h0, phase});
    reg_req <= 2'b10;
    tick(30);
    chk("phase", 8'h04, {5'h0, phase});
    reg_req <= 2'b00;
    pulse(40);
    chk("phase", 8'h00, {5'h0, phase});
    chk("idle", 8'h01, {7'h0, idle});
    rchk(ADDR_CTRL, 8'he6, "ctrl");
    rchk(ADDR_FLAGS, 8'h00, "");
    chk("flags", 8'h05, v & 8'h05);
    rchk(ADDR_FLAGS, 8'h00, "flags");
    // No recharge until the enable bit is written again
    wr(ADDR_CMD, 8'h01);
    tick(100);
    chk("run", 8'h00, {7'h0, run});
    wr(ADDR_CTRL, 8'he7);
    wphase(3'h3, 20);
    wphase(3'h0, 400);
    // Random current settings from 1 to 120
    for (k = 0; k < 8; k++) begin
      v = 8'(($unsigned($random(seed)) % 120) + 1);
      wr(ADDR_CHARGE_CURRENT_SETTING, v);
      tick(1);
      chk("charge_current_setting", v, charge_current_setting_out);
    end
    wr(ADDR_CHARGE_CURRENT_SETTING, 8'h78);
    rchk(ADDR_CHARGE_CURRENT_SETTING, 8'h78, "charge_current_setting");
    wr(ADDR_CHARGE_CURRENT_SETTING, 8'hff);
    rchk(ADDR_CHARGE_CURRENT_SETTING, 8'h78, "charge_current_setting");
    // Register reset keeps the mode
    wr(ADDR_CHARGE_VOLTAGE_TARGET, 8'h33);
    wr(ADDR_CMD, 8'h02);
    tick(1);
    chk("charge_voltage_target", 8'haa, charge_voltage_target_out);
    chk("charge_current_setting", 8'h46, charge_current_setting_out);
    chk("expired", 8'h00, {7'h0, expired});
    // Shortest watchdog period runs out: 40 seconds
    wr(ADDR_CTRL, 8'h53);
    wr(ADDR_CHARGE_CURRENT_SETTING, 8'h20);
    wr(ADDR_CMD, 8'h01);
    for (n = 0; n < 1000 && expired !== 1'b1; n++) tick(1);
    chk("wd_time", 8'h01, {7'h0, n >= 39 * SEC_C + 1 && n <= 40 * SEC_C});
    chk("run", 8'h00, {7'h0, run});
    chk("charge_current_setting", 8'h46, charge_current_setting_out);
    rchk(ADDR_CTRL, 8'h66, "ctrl");
    rchk(ADDR_STATUS, 8'h01, "status");
    // Period code zero never expires
    wr(ADDR_CMD, 8'h01);
    wr(ADDR_CTRL, 8'h26);
    tick(2000);
    chk("expired", 8'h00, {7'h0, expired});
    results;
  end
endmodule : test_chg_ctrl
`default_nettype wire
